//--- flash_host.sv
`timescale 1ns/10ps
module flash_host import flash_host_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire bus_req_type bus_req,
	output logic [31:0] bus_rdata,
	output strobe_type strobes,
	output logic byte_wide_n,
	output logic reset_powerdown_n,
	output logic reset_hv,
	output logic boot_unlock,
	output logic program_supply_level,
	output logic id_select_level,
	output logic [ADDR_W-1:0] addr_pins,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe,
	input wire logic [DATA_W-1:0] dq_in
);
	// Phase sequencer of one bus cycle
	typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD} ph_type;
	ph_type ph_ff, nxt_ph;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [1:0] step_ff, nxt_step;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	op_type op_ff, nxt_op;

	// Host-visible registers
	logic [ADDR_W:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] data_ff, nxt_data;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [DATA_W-1:0] rd_ff, nxt_rd;
	logic [31:0] rdata_ff, nxt_rdata;

	// Pin drive registers
	strobe_type str_ff, nxt_str;
	logic [ADDR_W-1:0] apin_ff, nxt_apin;
	logic [DATA_W-1:0] dout_ff, nxt_dout;
	logic [DATA_W-1:0] doe_ff, nxt_doe;
	logic vpp_ff, nxt_vpp;

	// Synchroniser for the returning data pins
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;

	// Decode of the current step
	logic is_write, word_mode;
	logic [7:0] cyc_cmd;

	// Refuse lengths and widths the logic cannot serve
	if (SETUP_CYC < 1 || SETUP_CYC > 15) begin : g_bad_setup
		$error("setup phase length out of range");
	end
	if (STROBE_CYC < 1 || STROBE_CYC > 15) begin : g_bad_strobe
		$error("strobe phase length out of range");
	end
	if (HOLD_CYC < 1 || HOLD_CYC > 15) begin : g_bad_hold
		$error("hold phase length out of range");
	end
	if (ID_SEL_BIT >= ADDR_W || DATA_W != 16) begin : g_bad_width
		$error("pin widths do not fit the remap logic");
	end

	// Bus width from CTRL
	assign word_mode = ctrl_ff[CTRL_WORD];

	// Decide whether the current step writes and which command byte
	always_comb begin
		is_write = 1'b1;
		cyc_cmd = CMD_READ_ARRAY;
		case (op_ff)
			OP_ERASE: cyc_cmd = (step_ff == 2'd0) ? CMD_ERASE_SETUP : CMD_ERASE_CONFIRM;
			OP_PROGRAM: cyc_cmd = CMD_PROG_SETUP;
			OP_READ_ARRAY: cyc_cmd = CMD_READ_ARRAY;
			OP_READ, OP_ID_READ: is_write = 1'b0;
			default: is_write = 1'b0;
		endcase
	end

	// Register read decode, answered one cycle later
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				REG_ADDR: nxt_rdata = 32'(addr_ff);
				REG_DATA: nxt_rdata = 32'(data_ff);
				REG_CTRL: nxt_rdata = 32'(ctrl_ff);
				REG_STATUS: nxt_rdata = {30'h0, done_ff, busy_ff};
				REG_RDATA: nxt_rdata = 32'(rd_ff);
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Command, register and pin sequencing
	always_comb begin
		logic last_step;
		last_step = 1'b1;
		// Hold every value unless a branch below changes it
		nxt_ph = ph_ff;
		nxt_cnt = cnt_ff;
		nxt_step = step_ff;
		nxt_busy = busy_ff;
		nxt_done = done_ff;
		nxt_op = op_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_ctrl = ctrl_ff;
		nxt_rd = rd_ff;
		nxt_str = str_ff;
		nxt_apin = apin_ff;
		nxt_dout = dout_ff;
		nxt_doe = doe_ff;
		nxt_vpp = vpp_ff;
		// Register writes; CTRL and CMD writes are ignored while busy
		if (bus_req.wr) begin
			case (bus_req.addr)
				REG_ADDR: nxt_addr = bus_req.wdata[ADDR_W:0];
				REG_DATA: nxt_data = bus_req.wdata[DATA_W-1:0];
				REG_CTRL: if (!busy_ff) nxt_ctrl = bus_req.wdata[7:0];
				REG_CMD: if (!busy_ff) begin
					nxt_op = op_type'(bus_req.wdata[2:0]);
					nxt_busy = 1'b1;
					nxt_done = 1'b0;
					nxt_step = 2'd0;
					nxt_ph = SETUP;
					nxt_cnt = SETUP_LEN;
				end
				default: ;
			endcase
		end
		// Program supply raised from the second step (erase confirm or program data write) until completion
		if (busy_ff && (op_ff == OP_ERASE || op_ff == OP_PROGRAM) && step_ff == 2'd1)
			nxt_vpp = 1'b1;
		if (!busy_ff)
			nxt_vpp = ctrl_ff[CTRL_VPP];
		last_step = !((op_ff == OP_ERASE || op_ff == OP_PROGRAM) && step_ff == 2'd0);
		// Phase steps of one flash cycle
		case (ph_ff)
			IDLE: begin
				nxt_str = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
				nxt_doe = '0;
			end
			SETUP: begin
				nxt_str.ce_n = 1'b0;
				nxt_str.oe_n = 1'b1;
				nxt_str.we_n = 1'b1;
				if (op_ff == OP_ID_READ)
					nxt_apin = ADDR_W'(1) & ADDR_W'(addr_ff[1]);
				else
					nxt_apin = word_mode ? addr_ff[ADDR_W:1] : addr_ff[ADDR_W:1];
				if (op_ff == OP_ID_READ)
					nxt_apin[ID_SEL_BIT] = 1'b0;
				nxt_doe = '0;
				if (is_write) begin
					if ((op_ff == OP_PROGRAM && step_ff == 2'd1)) begin
						nxt_dout = word_mode ? data_ff : {addr_ff[0], 7'h00, data_ff[7:0]};
						nxt_doe = word_mode ? '1 : {1'b1, 7'h00, 8'hFF};
					end else begin
						nxt_dout = {8'h00, cyc_cmd};
						nxt_doe = {8'h00, 8'hFF};
					end
				end else if (!word_mode) begin
					nxt_dout = {addr_ff[0], 15'h0000};
					nxt_doe = {1'b1, 15'h0000};
				end
				// Strobe falls at the end of setup
				if (cnt_ff <= CNT_ONE) begin
					nxt_ph = STROBE;
					nxt_cnt = STROBE_LEN;
					if (is_write)
						nxt_str.we_n = 1'b0;
					else
						nxt_str.oe_n = 1'b0;
				end else
					nxt_cnt = cnt_ff - CNT_ONE;
			end
			STROBE: begin
				if (cnt_ff <= CNT_ONE) begin
					nxt_str.we_n = 1'b1;
					nxt_str.oe_n = 1'b1;
					nxt_ph = HOLD;
					nxt_cnt = HOLD_LEN;
				end else
					nxt_cnt = cnt_ff - CNT_ONE;
			end
			HOLD: begin
				// Synchroniser delay: strobe-time pin data shows only now
				if (!is_write && cnt_ff == HOLD_LEN) begin
					if (word_mode)
						nxt_rd = dq_s2_ff;
					else
						nxt_rd = {8'h00, dq_s2_ff[7:0]};
				end
				if (cnt_ff <= CNT_ONE) begin
					nxt_doe = '0;
					// Close the cycle or start the next step
					if (last_step) begin
						nxt_ph = IDLE;
						nxt_busy = 1'b0;
						nxt_done = 1'b1;
						nxt_str.ce_n = 1'b1;
					end else begin
						nxt_step = step_ff + 2'd1;
						nxt_ph = SETUP;
						nxt_cnt = SETUP_LEN;
					end
				end else
					nxt_cnt = cnt_ff - CNT_ONE;
			end
			default: nxt_ph = IDLE;
		endcase
		// A STATUS read leaves done standing
		if (bus_req.rd && bus_req.addr == REG_STATUS && !bus_req.wr && !busy_ff)
			nxt_done = done_ff & ~(nxt_done == 1'b0);
	end

	// Register state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ph_ff <= IDLE;
			cnt_ff <= CNT_ZERO;
			step_ff <= 2'd0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			op_ff <= OP_READ;
			addr_ff <= '0;
			data_ff <= '0;
			ctrl_ff <= CTRL_RESET_VAL;
			rd_ff <= '0;
			rdata_ff <= '0;
			str_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			apin_ff <= '0;
			dout_ff <= '0;
			doe_ff <= '0;
			vpp_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			cnt_ff <= nxt_cnt;
			step_ff <= nxt_step;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			op_ff <= nxt_op;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			ctrl_ff <= nxt_ctrl;
			rd_ff <= nxt_rd;
			rdata_ff <= nxt_rdata;
			str_ff <= nxt_str;
			apin_ff <= nxt_apin;
			dout_ff <= nxt_dout;
			doe_ff <= nxt_doe;
			vpp_ff <= nxt_vpp;
		end
	end

	// Two-stage sync of the returning data pins
	always_ff @(posedge ref_clk) begin
		dq_s1_ff <= dq_in;
		dq_s2_ff <= dq_s1_ff;
	end

	// Slow control pins follow CTRL one cycle later; reset_hv stays low and the ID select pin follows a busy ID read
	logic byte_n_ff, rp_ff, hv_ff, unl_ff, idl_ff;
	logic nxt_byte_n, nxt_rp, nxt_hv, nxt_unl, nxt_idl;
	always_comb begin
		nxt_byte_n = ctrl_ff[CTRL_WORD];
		nxt_rp = ctrl_ff[CTRL_RST];
		nxt_hv = 1'b0; // Boot unlock uses its own pin
		nxt_unl = ctrl_ff[CTRL_UNLOCK];
		nxt_idl = busy_ff && op_ff == OP_ID_READ;
	end

	// Control pin registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			byte_n_ff <= 1'b0;
			rp_ff <= 1'b0;
			hv_ff <= 1'b0;
			unl_ff <= 1'b0;
			idl_ff <= 1'b0;
		end else begin
			byte_n_ff <= nxt_byte_n;
			rp_ff <= nxt_rp;
			hv_ff <= nxt_hv;
			unl_ff <= nxt_unl;
			idl_ff <= nxt_idl;
		end
	end

	// Every output comes straight from a register
	assign bus_rdata = rdata_ff;
	assign strobes = str_ff;
	assign byte_wide_n = byte_n_ff;
	assign reset_powerdown_n = rp_ff;
	assign reset_hv = hv_ff;
	assign boot_unlock = unl_ff;
	assign program_supply_level = vpp_ff;
	assign id_select_level = idl_ff;
	assign addr_pins = apin_ff;
	assign dq_out = dout_ff;
	assign dq_oe = doe_ff;
endmodule : flash_host

//--- flash_host_pkg.sv
package flash_host_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam int ID_SEL_BIT = 9;
	// Strobe phase lengths at 25 MHz
	localparam int SETUP_NS = 40;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int CLK_NS = 40;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] SETUP_LEN = 4'(SETUP_CYC);
	localparam logic [3:0] STROBE_LEN = 4'(STROBE_CYC);
	localparam logic [3:0] HOLD_LEN = 4'(HOLD_CYC);
	// Host register map
	localparam logic [3:0] REG_ADDR = 4'h0;
	localparam logic [3:0] REG_DATA = 4'h1;
	localparam logic [3:0] REG_CTRL = 4'h2;
	localparam logic [3:0] REG_CMD = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RDATA = 4'h5;
	localparam int CTRL_WORD = 0;
	localparam int CTRL_VPP = 1;
	localparam int CTRL_UNLOCK = 2;
	localparam int CTRL_RST = 3;
	localparam int CTRL_ID = 4;
	localparam logic [7:0] CTRL_RESET_VAL = 8'h08;
	typedef enum logic [2:0] {
		OP_READ, OP_ERASE, OP_PROGRAM, OP_READ_ARRAY, OP_ID_READ
	} op_type;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} strobe_type;
endpackage : flash_host_pkg

//--- flash_host_assertions.sv
`timescale 1ns/10ps
module flash_host_assertions import flash_host_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire strobe_type strobes,
	input wire logic byte_wide_n,
	input wire logic program_supply_level,
	input wire logic id_select_level,
	input wire logic [ADDR_W-1:0] addr_pins,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic [DATA_W-1:0] dq_oe
);
	logic we_ff, dirty_ff, nxt_we, nxt_dirty, start;
	logic [7:0] last_ff, nxt_last;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// First cycle of a device write
	assign start = !strobes.we_n && !strobes.ce_n && we_ff;
	// Last byte written and pending read-array
	always_comb begin
		nxt_we = strobes.we_n | reset;
		nxt_last = reset ? 8'hFF : (start ? dq_out[7:0] : last_ff);
		nxt_dirty = reset ? 1'b0 : dirty_ff;
		if (start && (last_ff == CMD_ERASE_SETUP || last_ff == CMD_PROG_SETUP)) nxt_dirty = 1'b1;
		else if (start && dq_out[7:0] == CMD_READ_ARRAY) nxt_dirty = 1'b0;
	end
	// History registers
	always_ff @(posedge ref_clk) begin
		we_ff <= nxt_we;
		last_ff <= nxt_last;
		dirty_ff <= nxt_dirty;
	end
	sequence cmd_wr(logic [7:0] c);
		start && dq_out[7:0] == c;
	endsequence
	a_cmd_low_byte: assert property (start |-> dq_oe[7:0] == 8'hFF)
		else $error("low byte not driven on write");
	a_vpp_confirm: assert property (cmd_wr(CMD_ERASE_CONFIRM) |-> program_supply_level [*4])
		else $error("program supply low after confirm");
	a_confirm_order: assert property (cmd_wr(CMD_ERASE_CONFIRM) |-> last_ff == CMD_ERASE_SETUP || last_ff == CMD_PROG_SETUP)
		else $error("confirm without setup");
	a_erase_pair: assert property (cmd_wr(CMD_ERASE_SETUP) |-> ##[1:30] start)
		else $error("erase setup not followed");
	a_prog_pair: assert property (cmd_wr(CMD_PROG_SETUP) |-> ##[1:30] start)
		else $error("program setup not followed");
	a_read_after: assert property ($fell(strobes.oe_n) && !id_select_level |-> !dirty_ff)
		else $error("array read without read-array");
	a_id_addr: assert property (id_select_level && !strobes.ce_n |-> addr_pins[18:10] == '0 && addr_pins[8:1] == '0)
		else $error("id read address not low");
	a_top_pin: assert property (!byte_wide_n && (!strobes.ce_n && !strobes.oe_n
		|| start && last_ff == CMD_PROG_SETUP) |-> dq_oe[15])
		else $error("top pin not driven in byte mode");
endmodule : flash_host_assertions
bind flash_host flash_host_assertions chk (.ref_clk(ref_clk), .reset(reset), .strobes(strobes),
	.byte_wide_n(byte_wide_n), .program_supply_level(program_supply_level),
	.id_select_level(id_select_level), .addr_pins(addr_pins), .dq_out(dq_out), .dq_oe(dq_oe));

//--- flash_model.sv
`timescale 1ns/10ps
module flash_model import flash_host_pkg::*; #(
	parameter logic [15:0] MFR_CODE = 16'h3A11, // Arbitrary maker code
	parameter logic [15:0] DEV_CODE = 16'h3A22 // Arbitrary part code
) (
	input wire strobe_type strobes,
	input wire logic byte_wide_n,
	input wire logic reset_powerdown_n,
	input wire logic reset_hv,
	input wire logic boot_unlock,
	input wire logic program_supply_level,
	input wire logic id_select_level,
	input wire logic [ADDR_W-1:0] addr_pins,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic [DATA_W-1:0] dq_oe,
	output logic [DATA_W-1:0] dq_in
);
	logic [7:0] mem [0:255];
	logic [1:0] mode;
	logic [15:0] drv, last, hiz;
	logic [7:0] a;
	logic on, wr_ok;
	// Top sixteen bytes act as the protected boot block
	assign wr_ok = program_supply_level && (boot_unlock || reset_hv || a < 8'hF0);
	assign a = {addr_pins[6:0], byte_wide_n ? 1'b0 : dq_out[15]};
	assign on = reset_powerdown_n && !strobes.ce_n && !strobes.oe_n && strobes.we_n;
	initial begin
		mode = 2'h0;
		last = 16'h0;
		foreach (mem[i]) mem[i] = 8'hFF;
	end
	// Command decode at the end of each write strobe
	always @(posedge strobes.we_n or negedge reset_powerdown_n) begin
		if (!reset_powerdown_n) mode = 2'h0;
		else if (!strobes.ce_n) begin
			if (mode == 2'h1 && dq_out[7:0] == CMD_ERASE_CONFIRM && program_supply_level) begin
				foreach (mem[i]) if (boot_unlock || reset_hv || i < 8'hF0) mem[i] = 8'hFF;
			end
			if (mode == 2'h2 && wr_ok) mem[a] = dq_out[7:0];
			if (mode == 2'h2 && wr_ok && byte_wide_n) mem[a + 1] = dq_out[15:8];
			if (mode != 2'h0 && mode != 2'h3) mode = 2'h3;
			else if (dq_out[7:0] == CMD_ERASE_SETUP) mode = 2'h1;
			else if (dq_out[7:0] == 8'h10 || dq_out[7:0] == CMD_PROG_SETUP) mode = 2'h2;
			else mode = (dq_out[7:0] == CMD_READ_ARRAY) ? 2'h0 : 2'h3;
		end
	end
	// Read data; released pins show the inverse of the last value
	always @* begin
		drv = id_select_level ? (addr_pins[0] ? DEV_CODE : MFR_CODE) : {mem[a + 1], mem[a]};
		if (mode == 2'h3 && !id_select_level) drv = 16'h0080;
		hiz = on ? (byte_wide_n ? 16'h0000 : 16'h7F00) : 16'hFFFF;
		if (on) last = drv;
		dq_in = (dq_oe & dq_out) | (~dq_oe & ((drv & ~hiz) | (~last & hiz)));
	end
endmodule : flash_model

//--- parallel_flash_bus_interface_bench.sv
`timescale 1ns/10ps
module parallel_flash_bus_interface_bench import flash_host_pkg::*; ;
	logic ref_clk, reset, byte_wide_n, reset_powerdown_n, reset_hv, boot_unlock;
	logic program_supply_level, id_select_level;
	bus_req_type bus_req;
	logic [31:0] bus_rdata;
	strobe_type strobes;
	logic [ADDR_W-1:0] addr_pins;
	logic [DATA_W-1:0] dq_out, dq_oe, dq_in;
	int errors = 0;
	int tests_run = 0;
	flash_host dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.strobes(strobes), .byte_wide_n(byte_wide_n), .reset_powerdown_n(reset_powerdown_n),
		.reset_hv(reset_hv), .boot_unlock(boot_unlock), .program_supply_level(program_supply_level),
		.id_select_level(id_select_level), .addr_pins(addr_pins), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	flash_model model (.strobes(strobes), .byte_wide_n(byte_wide_n),
		.reset_hv(reset_hv), .boot_unlock(boot_unlock),
		.reset_powerdown_n(reset_powerdown_n), .program_supply_level(program_supply_level),
		.id_select_level(id_select_level), .addr_pins(addr_pins), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task check(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected rdata expected %h seen %h", exp, got);
		end
	endtask : check
	task check_pin(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %b seen %b", name, exp, got);
		end
	endtask : check_pin
	task wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge ref_clk) bus_req <= '{ad, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus_req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] ad, input logic [31:0] exp, input logic [31:0] mask);
		@(posedge ref_clk) bus_req <= '{ad, 32'h0, 1'b0, 1'b1};
		@(posedge ref_clk) bus_req.rd <= 1'b0;
		#1 check(exp, bus_rdata & mask);
	endtask : rd
	task op(input logic [31:0] code);
		int n;
		wr(REG_CMD, code);
		n = 0;
		do begin
			@(posedge ref_clk) bus_req <= '{REG_STATUS, 32'h0, 1'b0, 1'b1};
			@(posedge ref_clk) bus_req.rd <= 1'b0;
			#1 n++;
		end while (bus_rdata[1] !== 1'b1 && n < 40);
		if (n == 40) begin
			errors++;
			end_sim();
		end
	endtask : op
	task program_word(input logic [31:0] ad, input logic [31:0] d);
		wr(REG_ADDR, ad);
		wr(REG_DATA, d);
		op(32'h2);
		op(32'h3);
	endtask : program_word
	// Main sequence
	initial begin
		reset = 1'b1;
		bus_req = '0;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd(REG_CTRL, 32'h08, 32'hFF);
		rd(REG_STATUS, 32'h0, 32'h3);
		wr(REG_CTRL, 32'h0B);
		program_word(32'h10, 32'hA55A);
		op(32'h0);
		rd(REG_RDATA, 32'hA55A, 32'hFFFF);
		check_pin("reset_powerdown_n", 1'b1, reset_powerdown_n);
		check_pin("boot_unlock", 1'b0, boot_unlock);
		check_pin("reset_hv", 1'b0, reset_hv);
		program_word(32'hF0, 32'h1234);
		op(32'h0);
		rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
		wr(REG_CTRL, 32'h0F);
		program_word(32'hF0, 32'h1234);
		op(32'h0);
		rd(REG_RDATA, 32'h1234, 32'hFFFF);
		check_pin("boot_unlock", 1'b1, boot_unlock);
		wr(REG_CTRL, 32'h0A);
		program_word(32'h11, 32'h3C);
		op(32'h0);
		rd(REG_RDATA, 32'h3C, 32'hFF);
		wr(REG_ADDR, 32'h10);
		op(32'h0);
		rd(REG_RDATA, 32'h5A, 32'hFF);
		op(32'h4);
		rd(REG_RDATA, {24'h0, model.MFR_CODE[7:0]}, 32'hFF);
		wr(REG_CTRL, 32'h09);
		wr(REG_ADDR, 32'h2);
		op(32'h4);
		rd(REG_RDATA, {16'h0, model.DEV_CODE}, 32'hFFFF);
		wr(REG_ADDR, 32'h0);
		op(32'h4);
		rd(REG_RDATA, {16'h0, model.MFR_CODE}, 32'hFFFF);
		wr(REG_ADDR, 32'h10);
		op(32'h1);
		op(32'h3);
		op(32'h0);
		rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		end_sim();
	end
endmodule : parallel_flash_bus_interface_bench
